// file: rtl/alu_accum_logic.sv
// accumulator logical operations with zero and negative flags
`timescale 1ns/1ps
module alu_accum_logic
  import alu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // operation request
  input wire logic op_valid,
  input wire alu_pkg::alu_op_t op_code,
  output logic op_ready,
  // operands from the sequencer
  input wire logic [alu_pkg::WORD_W-1:0] operand_mem_lo,
  input wire logic [alu_pkg::WORD_W-1:0] operand_mem_hi,
  input wire logic operand_const_sel,
  input wire logic [alu_pkg::DATA_W-1:0] operand_const,
  input wire logic [alu_pkg::DATA_W-1:0] fmt_bits,
  input wire logic [alu_pkg::CNT_W-1:0] fmt_bit_count,
  // completion
  output logic op_done,
  output logic op_error,
  // accumulator and stack view
  output logic [alu_pkg::DATA_W-1:0] acc_value,
  output logic [alu_pkg::DATA_W-1:0] stack_top,
  output logic [alu_pkg::DEPTH_W-1:0] stack_depth,
  // status flags
  output logic zero_result_flag,
  output logic negative_result_flag
);

  import alu_pkg::*;

  alu_state_t st_reg;
  alu_state_t st_next;
  logic take;
  logic stack_pop;
  logic stack_push;
  logic [DATA_W-1:0] dbl_operand;
  logic [DATA_W-1:0] fmt_mask;
  logic [DATA_W:0] fmt_span;
  logic fmt_count_ok;
  logic [DATA_W-1:0] result;
  logic set_zero;
  logic set_neg;
  logic refuse;

  //--------------------------------------------------------------------
  // accumulator stack
  //--------------------------------------------------------------------
  alu_stack u_stack (
    .clk(clk),
    .reset_n(reset_n),
    .push(stack_push),
    .push_data(st_reg.acc),
    .pop(stack_pop),
    .top(stack_top),
    .depth(stack_depth)
  );

  //--------------------------------------------------------------------
  // operand shaping
  //--------------------------------------------------------------------
  // one operation at a time; result and flags land on the taking edge
  assign take = op_valid && (st_reg.fsm == ALU_ST_IDLE);
  assign op_ready = (st_reg.fsm == ALU_ST_IDLE);
  // high word is the second of the two consecutive locations
  assign dbl_operand = operand_const_sel ? operand_const :
                       {operand_mem_hi, operand_mem_lo};
  // run mask; a 33-bit span keeps a count of 32 from wrapping
  assign fmt_span = ({{DATA_W{1'b0}}, 1'b1} << fmt_bit_count) -
                    {{DATA_W{1'b0}}, 1'b1};
  assign fmt_mask = fmt_span[DATA_W-1:0];
  assign fmt_count_ok = (fmt_bit_count >= BIT_COUNT_MIN) &&
                        (fmt_bit_count <= BIT_COUNT_MAX);

  //--------------------------------------------------------------------
  // operation decode
  //--------------------------------------------------------------------
  always_comb
  begin
    result = st_reg.acc;
    set_zero = 1'b0;
    set_neg = 1'b0;
    refuse = 1'b0;
    stack_pop = 1'b0;
    stack_push = 1'b0;
    if (take)
    begin
      case (op_code)
        ALU_OP_AND_WITH_STACK:
        begin
          result = st_reg.acc & stack_top;
          stack_pop = 1'b1;
          set_zero = 1'b1;
          set_neg = 1'b1;
        end
        ALU_OP_OR_WORD:
        begin
          // word operations clear the upper half
          result = {{WORD_W{1'b0}},
                    st_reg.acc[WORD_W-1:0] | operand_mem_lo};
          set_zero = 1'b1;
        end
        ALU_OP_OR_DOUBLE:
        begin
          result = st_reg.acc | dbl_operand;
          set_zero = 1'b1;
          set_neg = 1'b1;
        end
        ALU_OP_OR_FORMATTED:
        begin
          if (fmt_count_ok)
          begin
            result = st_reg.acc | (fmt_bits & fmt_mask);
            set_zero = 1'b1;
            set_neg = 1'b1;
          end
          else
          begin
            // a bad count changes nothing, only reports
            refuse = 1'b1;
          end
        end
        ALU_OP_OR_WITH_STACK:
        begin
          result = st_reg.acc | stack_top;
          stack_pop = 1'b1;
          set_zero = 1'b1;
          set_neg = 1'b1;
        end
        ALU_OP_XOR_WORD:
        begin
          result = {{WORD_W{1'b0}},
                    st_reg.acc[WORD_W-1:0] ^ operand_mem_lo};
          set_zero = 1'b1;
        end
        ALU_OP_XOR_DOUBLE:
        begin
          result = st_reg.acc ^ dbl_operand;
          set_zero = 1'b1;
          set_neg = 1'b1;
        end
        ALU_OP_LOAD_ACC:
        begin
          // old accumulator goes onto the stack, flags untouched
          result = dbl_operand;
          stack_push = 1'b1;
        end
        default:
        begin
          refuse = 1'b1;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  // flags change only when an operation that uses them runs
  always_comb
  begin
    st_next = st_reg;
    st_next.error = 1'b0;
    case (st_reg.fsm)
      ALU_ST_IDLE:
      begin
        if (take)
        begin
          st_next.fsm = ALU_ST_DONE;
          st_next.acc = result;
          st_next.error = refuse;
          if (set_zero)
          begin
            st_next.zero_result_flag = (result == ACC_RESET);
          end
          if (set_neg)
          begin
            st_next.negative_result_flag = result[MSB_POS];
          end
        end
      end
      ALU_ST_DONE:
      begin
        st_next.fsm = ALU_ST_IDLE;
      end
      default:
      begin
        st_next.fsm = ALU_ST_IDLE;
      end
    endcase
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  // all-zero record: idle, accumulator clear, flags low
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign acc_value = st_reg.acc;
  assign zero_result_flag = st_reg.zero_result_flag;
  assign negative_result_flag = st_reg.negative_result_flag;
  assign op_done = (st_reg.fsm == ALU_ST_DONE);
  assign op_error = st_reg.error;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  a_and_with_stack_op_value: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_AND_WITH_STACK |=>
    acc_value == ($past(acc_value) & $past(stack_top)))
    else $error("and-with-stack result wrong");

  a_stack_pop: assert property (@(posedge clk) disable iff (!reset_n)
    take && (op_code == ALU_OP_AND_WITH_STACK ||
    op_code == ALU_OP_OR_WITH_STACK) && stack_depth != '0 |=>
    stack_depth == $past(stack_depth) - DEPTH_ONE)
    else $error("stack not popped");

  a_and_with_stack_op_flags: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_AND_WITH_STACK |=>
    zero_result_flag == (acc_value == '0) &&
    negative_result_flag == acc_value[31])
    else $error("and-with-stack flags wrong");

  a_or_word: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_WORD |=>
    acc_value == {16'h0000, $past(acc_value[15:0]) |
    $past(operand_mem_lo)})
    else $error("word or result wrong");

  a_word_neg_kept: assert property (@(posedge clk) disable iff (!reset_n)
    take && (op_code == ALU_OP_OR_WORD || op_code == ALU_OP_XOR_WORD)
    |=> $stable(negative_result_flag) &&
    zero_result_flag == (acc_value == '0))
    else $error("word op flags wrong");

  a_or_double: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_DOUBLE |=>
    acc_value == ($past(acc_value) | $past(dbl_operand)))
    else $error("double or result wrong");

  a_double_flags: assert property (@(posedge clk) disable iff (!reset_n)
    take && (op_code == ALU_OP_OR_DOUBLE ||
    op_code == ALU_OP_XOR_DOUBLE) |=>
    negative_result_flag == acc_value[31] &&
    zero_result_flag == (acc_value == '0))
    else $error("double op flags wrong");

  a_orf_value: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_FORMATTED && fmt_count_ok |=>
    acc_value == ($past(acc_value) | ($past(fmt_bits) &
    $past(fmt_mask))) && negative_result_flag == acc_value[31])
    else $error("formatted or result wrong");

  a_orf_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_FORMATTED && !fmt_count_ok |=>
    $stable(acc_value) && op_error && op_done)
    else $error("bad bit count not refused");

  a_ors_value: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_WITH_STACK |=>
    acc_value == ($past(acc_value) | $past(stack_top)) &&
    zero_result_flag == (acc_value == '0))
    else $error("or-with-stack result wrong");

  a_xor_word: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_XOR_WORD |=>
    acc_value == {16'h0000, $past(acc_value[15:0]) ^
    $past(operand_mem_lo)})
    else $error("word xor result wrong");

  a_xor_double: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_XOR_DOUBLE |=>
    acc_value == ($past(acc_value) ^ $past(dbl_operand)))
    else $error("double xor result wrong");

  a_flags_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !take |=> $stable(zero_result_flag) &&
    $stable(negative_result_flag) && $stable(acc_value))
    else $error("flags moved without an operation");

  a_fmt_bit0: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == ALU_OP_OR_FORMATTED && fmt_count_ok &&
    fmt_bits[0] |=> acc_value[0])
    else $error("first discrete bit not in bit zero");

  a_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    take |=> op_done && !op_ready ##1 !op_done && op_ready)
    else $error("done not a single pulse");

endmodule : alu_accum_logic

// file: rtl/alu_pkg.sv
// constants, types and state layouts of the accumulator logic unit
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package alu_pkg;

  //--------------------------------------------------------------------
  // widths and sizes
  //--------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int MSB_POS = 31;
  localparam int CNT_W = 6;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;

  //--------------------------------------------------------------------
  // values
  //--------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STACK_FILL = 32'h0000_0000;
  localparam logic [CNT_W-1:0] BIT_COUNT_MIN = 6'h01;
  localparam logic [CNT_W-1:0] BIT_COUNT_MAX = 6'h20;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;

  //--------------------------------------------------------------------
  // operation codes
  //--------------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_OP_AND_WITH_STACK,
    ALU_OP_OR_WORD,
    ALU_OP_OR_DOUBLE,
    ALU_OP_OR_FORMATTED,
    ALU_OP_OR_WITH_STACK,
    ALU_OP_XOR_WORD,
    ALU_OP_XOR_DOUBLE,
    ALU_OP_LOAD_ACC
  } alu_op_t;

  typedef enum logic [0:0] {
    ALU_ST_IDLE,
    ALU_ST_DONE
  } alu_fsm_t;

  //--------------------------------------------------------------------
  // state records
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [STACK_DEPTH-1:0][DATA_W-1:0] entry;
    logic [DEPTH_W-1:0] depth;
  } alu_stack_state_t;

  typedef struct packed {
    alu_fsm_t fsm;
    logic [DATA_W-1:0] acc;
    logic zero_result_flag;
    logic negative_result_flag;
    logic error;
  } alu_state_t;

endpackage : alu_pkg

// file: rtl/alu_stack.sv
// accumulator stack: push on top, pop shifts every level up
`timescale 1ns/1ps
module alu_stack
  import alu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // stack control
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic pop,
  // stack view
  output logic [DATA_W-1:0] top,
  output logic [DEPTH_W-1:0] depth
);

  import alu_pkg::*;

  alu_stack_state_t st_reg;
  alu_stack_state_t st_next;

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  // pop first, then push, so a same-cycle pair replaces the top
  always_comb
  begin
    st_next = st_reg;
    if (pop)
    begin
      // deeper levels move up, bottom refills with zero
      for (int i = 0; i < STACK_DEPTH - 1; i++)
      begin
        st_next.entry[i] = st_reg.entry[i+1];
      end
      st_next.entry[STACK_DEPTH-1] = STACK_FILL;
      if (st_reg.depth != '0)
      begin
        st_next.depth = st_reg.depth - DEPTH_ONE;
      end
    end
    if (push)
    begin
      // full stack loses its deepest entry
      for (int i = STACK_DEPTH - 1; i > 0; i--)
      begin
        st_next.entry[i] = st_next.entry[i-1];
      end
      st_next.entry[0] = push_data;
      if (st_next.depth != DEPTH_FULL)
      begin
        st_next.depth = st_next.depth + DEPTH_ONE;
      end
    end
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign top = st_reg.entry[0];
  assign depth = st_reg.depth;

endmodule : alu_stack

// file: tb/alu_opmem_model.sv
// operand memory model: word memory and discrete bit image
`timescale 1ns/1ps
module alu_opmem_model
  import alu_pkg::*;
(
  // read request from the sequencer side
  input wire logic rd_en,
  input wire logic [3:0] word_addr,
  input wire logic [5:0] bit_start,
  // operands to the block
  output logic [alu_pkg::WORD_W-1:0] mem_lo,
  output logic [alu_pkg::WORD_W-1:0] mem_hi,
  output logic [alu_pkg::DATA_W-1:0] bits
);
  //--------------------------------------------------------------------
  // contents
  //--------------------------------------------------------------------
  localparam logic [63:0] DISC_IMAGE = 64'hF0E1_D2C3_B4A5_9687;
  logic [WORD_W-1:0] mem [16];
  logic [WORD_W-1:0] lo_w;
  logic [WORD_W-1:0] hi_w;
  logic [DATA_W-1:0] run_w;

  // every address holds a different word so a wrong index shows
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 16'(i * 16'h1111) ^ 16'h8421;
    end
  end

  //--------------------------------------------------------------------
  // read paths
  //--------------------------------------------------------------------
  // pair is the addressed word and the next one, wraps at the top
  assign lo_w = mem[word_addr];
  assign hi_w = mem[word_addr + 4'h1];
  // start address lands on bit 0, later addresses climb
  assign run_w = DATA_W'(DISC_IMAGE >> bit_start);
  // no read: show the inverse so stale data cannot pass as good
  assign mem_lo = rd_en ? lo_w : ~lo_w;
  assign mem_hi = rd_en ? hi_w : ~hi_w;
  assign bits = rd_en ? run_w : ~run_w;
endmodule : alu_opmem_model

// file: tb/tb.sv
// self-checking bench for the accumulator logic unit
`timescale 1ns/1ps
module tb;
  import alu_pkg::*;
  //--------------------------------------------------------------------
  // signals
  //--------------------------------------------------------------------
  localparam logic [63:0] DISC = 64'hF0E1_D2C3_B4A5_9687;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  alu_op_t op_code = ALU_OP_LOAD_ACC;
  logic sel = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] k = 32'h0;
  logic [CNT_W-1:0] cnt = 6'h01;
  logic [3:0] wa = 4'h0;
  logic [5:0] bs = 6'h00;
  logic op_ready, op_done, op_error, zf, nf;
  logic [WORD_W-1:0] mem_lo, mem_hi;
  logic [DATA_W-1:0] bits, acc, top;
  logic [DEPTH_W-1:0] depth;
  logic [DATA_W-1:0] ea;
  logic ez, en;
  int fails = 0;
  int n_tests = 0;

  // 40 MHz
  always #12.5 clk = ~clk;

  alu_opmem_model i_mem (.rd_en(rd_en), .word_addr(wa), .bit_start(bs),
    .mem_lo(mem_lo), .mem_hi(mem_hi), .bits(bits));

  alu_accum_logic i_dut (.clk(clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .operand_mem_lo(mem_lo), .operand_mem_hi(mem_hi),
    .operand_const_sel(sel), .operand_const(k), .fmt_bits(bits),
    .fmt_bit_count(cnt), .op_done(op_done), .op_error(op_error),
    .acc_value(acc), .stack_top(top), .stack_depth(depth),
    .zero_result_flag(zf), .negative_result_flag(nf));

  //--------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // accumulator and both flags against the running expectation
  task automatic chk_res();
    chk("acc_value", ea, acc);
    chk("zero_result_flag", {31'h0, ez}, {31'h0, zf});
    chk("negative_result_flag", {31'h0, en}, {31'h0, nf});
  endtask : chk_res

  task automatic chk_stk(input logic [31:0] t, input logic [3:0] d);
    chk("stack_top", t, top);
    chk("stack_depth", {28'h0, d}, {28'h0, depth});
  endtask : chk_stk

  // flags follow ea; word ops leave negative alone
  task automatic calc(input logic neg_too);
    ez = (ea == 32'h0);
    if (neg_too)
    begin
      en = ea[31];
    end
  endtask : calc

  // one request, held until taken; done is due one cycle later
  task automatic do_op(input alu_op_t op, input logic [31:0] kv,
    input logic cs, input logic [3:0] a, input logic [5:0] s,
    input logic [5:0] c, input logic err);
    int i;
    @(negedge clk);
    op_valid = 1'b1;
    op_code = op;
    k = kv;
    sel = cs;
    wa = a;
    bs = s;
    cnt = c;
    rd_en = 1'b1;
    i = 0;
    while (op_ready !== 1'b1)
    begin
      @(negedge clk);
      i++;
      if (i > 8)
      begin
        fails++;
        tally_and_finish();
      end
    end
    @(negedge clk);
    chk("op_done", 32'h1, {31'h0, op_done});
    chk("op_error", {31'h0, err}, {31'h0, op_error});
    chk("op_ready", 32'h0, {31'h0, op_ready});
    op_valid = 1'b0;
    rd_en = 1'b0;
    k = ~k;
  endtask : do_op

  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task automatic s_reset();
    ea = 32'h0;
    ez = 1'b0;
    en = 1'b0;
    chk_res();
    chk_stk(32'h0, 4'h0);
  endtask : s_reset

  // three loads push three of the eight levels, then pops through with-stack ops
  task automatic s_stack();
    do_op(ALU_OP_LOAD_ACC, 32'hF0F0_00FF, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    do_op(ALU_OP_LOAD_ACC, 32'h8F00_00F1, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    do_op(ALU_OP_LOAD_ACC, 32'hFF00_0F0F, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    ea = 32'hFF00_0F0F;
    chk_res();
    do_op(ALU_OP_AND_WITH_STACK, 32'h0, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    ea = ea & 32'h8F00_00F1;
    calc(1'b1);
    chk_res();
    chk_stk(32'hF0F0_00FF, 4'h2);
    do_op(ALU_OP_OR_WITH_STACK, 32'h0, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    ea = ea | 32'hF0F0_00FF;
    calc(1'b1);
    chk_res();
    chk_stk(32'h0, 4'h1);
    do_op(ALU_OP_AND_WITH_STACK, 32'h0, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    ea = 32'h0;
    calc(1'b1);
    chk_res();
    chk_stk(32'h0, 4'h0);
  endtask : s_stack

  // negative set first, then word ops must leave it standing
  task automatic s_word();
    logic [15:0] m;
    m = i_mem.mem[5];
    do_op(ALU_OP_LOAD_ACC, {16'h8000, m}, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    do_op(ALU_OP_XOR_DOUBLE, 32'h0, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    ea = {16'h8000, m};
    calc(1'b1);
    chk_res();
    do_op(ALU_OP_OR_WORD, 32'h0, 1'b0, 4'h5, 6'h0, 6'h1, 1'b0);
    ea = {16'h0, m};
    calc(1'b0);
    chk_res();
    do_op(ALU_OP_XOR_WORD, 32'h0, 1'b0, 4'h5, 6'h0, 6'h1, 1'b0);
    ea = 32'h0;
    calc(1'b0);
    chk_res();
  endtask : s_word

  // double ops from a memory pair and from a constant
  task automatic s_double();
    logic [31:0] p;
    p = {i_mem.mem[3], i_mem.mem[2]};
    do_op(ALU_OP_OR_DOUBLE, 32'h0, 1'b0, 4'h2, 6'h0, 6'h1, 1'b0);
    ea = ea | p;
    calc(1'b1);
    chk_res();
    do_op(ALU_OP_XOR_DOUBLE, 32'h0, 1'b0, 4'h2, 6'h0, 6'h1, 1'b0);
    ea = ea ^ p;
    calc(1'b1);
    chk_res();
    do_op(ALU_OP_OR_DOUBLE, 32'h0FFF_FFFF, 1'b1, 4'h2, 6'h0, 6'h1, 1'b0);
    ea = ea | 32'h0FFF_FFFF;
    calc(1'b1);
    chk_res();
    do_op(ALU_OP_XOR_DOUBLE, 32'hFFFF_FFFF, 1'b1, 4'h2, 6'h0, 6'h1, 1'b0);
    ea = ea ^ 32'hFFFF_FFFF;
    calc(1'b1);
    chk_res();
  endtask : s_double

  // run lengths at both ends of the legal range, acc cleared first
  task automatic s_fmt();
    logic [5:0] cs [4] = '{6'h01, 6'h04, 6'h1F, 6'h20};
    logic [5:0] ss [4] = '{6'h00, 6'h03, 6'h05, 6'h00};
    logic [31:0] mk;
    for (int i = 0; i < 4; i++)
    begin
      do_op(ALU_OP_XOR_DOUBLE, ea, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
      mk = (cs[i] == 6'h20) ? 32'hFFFF_FFFF : (32'h1 << cs[i]) - 32'h1;
      do_op(ALU_OP_OR_FORMATTED, 32'h0, 1'b0, 4'h0, ss[i], cs[i], 1'b0);
      ea = 32'(DISC >> ss[i]) & mk;
      calc(1'b1);
      chk_res();
    end
  endtask : s_fmt

  // refused requests change nothing, flags included
  task automatic s_refuse();
    do_op(ALU_OP_OR_FORMATTED, 32'h0, 1'b0, 4'h0, 6'h0, 6'h00, 1'b1);
    chk_res();
    do_op(ALU_OP_OR_FORMATTED, 32'h0, 1'b0, 4'h0, 6'h0, 6'h21, 1'b1);
    chk_res();
    do_op(alu_op_t'(4'hF), 32'h0, 1'b1, 4'h0, 6'h0, 6'h1, 1'b1);
    chk_res();
  endtask : s_refuse

  // request still held in the done cycle must not be taken twice
  task automatic s_hold();
    @(negedge clk);
    op_valid = 1'b1;
    op_code = ALU_OP_XOR_DOUBLE;
    sel = 1'b1;
    k = 32'h0000_0F0F;
    repeat (2) @(negedge clk);
    op_valid = 1'b0;
    ea = ea ^ 32'h0000_0F0F;
    calc(1'b1);
    chk_res();
    chk("op_done", 32'h0, {31'h0, op_done});
  endtask : s_hold

  // reset in mid-run clears acc, flags and a non-empty stack
  task automatic s_midreset();
    do_op(ALU_OP_LOAD_ACC, 32'h1234_5678, 1'b1, 4'h0, 6'h0, 6'h1, 1'b0);
    chk_stk(ea, 4'h2);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    s_reset();
  endtask : s_midreset

  //--------------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    s_reset();
    s_stack();
    s_word();
    s_double();
    s_fmt();
    s_refuse();
    s_hold();
    s_midreset();
    tally_and_finish();
  end
endmodule : tb
